// >>> msi_product_data_capability_header_regs.sv
// Purpose: Message interrupt, product data and vendor capability registers of a switch port
// Assumes: Single clock mclk, plain register port, EEPROM handshake on same clock
// Notes: Interrupt event is a one-cycle pulse from port logic
//
// How it works
// RL1 - Message enable permits message writes, blocks legacy pin; resets to zero
// RL2 - Wide address capable bit is read-only and reads one
// RL3 - Message address bits 31:2 hold aligned target; low bits read zero
// RL4 - Upper address used only when wide addressing is advertised
// RL5 - Product data header low byte reads 03h
// RL6 - Product data header next pointer reads 64h
// RL7 - Six-bit table word address in bits 23:18, resets to zero
// RL8 - Writing flag zero starts a read; flag set when read completes
// RL9 - Writing flag one starts a write; flag cleared when write completes
// RL10 - Data register returns last word written to it or fetched from the table
// RL11 - Written data word is stored by the following write operation
// RL12 - Vendor header low byte reads 09h
// RL13 - Vendor header next pointer reads B0h
// RL14 - Vendor length field in bits 31:16 reads 0034h
// RL15 - Message capability header low byte reads 05h
// RL16 - On an event with messaging on, issue write of address and payload
// RL17 - Software loads data before write and polls flag between accesses
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "mvcr_defines.svh"
module msi_product_data_capability_header_regs (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  input wire logic serviceEvent,
  output logic msgWriteValid,
  output mvcr_pkg::mvcr_msg_s msgWrite,
  output logic legacyIntActive,
  output logic irq,
  output logic eeReq,
  output mvcr_pkg::mvcr_pd_req_s eeCmd,
  input wire logic eeDone,
  input wire logic [31:0] eeReadData
);

  logic msgEnable;
  logic [2:0] multiMsgEnable;
  logic [29:0] msgAddr;
  logic [31:0] msgUpper;
  logic [15:0] msgPayload;
  logic [5:0] pdAddr;
  logic pdFlag;
  logic [31:0] pdWrWord;
  logic [31:0] testWord0;
  logic [`MVCR_IRQ_BITS-1:0] irqStatus;
  logic [`MVCR_IRQ_BITS-1:0] irqMask;
  logic [`MVCR_IRQ_BITS-1:0] irqEvent;
  logic pdStart;
  logic pdBusy;
  logic pdFinish;
  logic [31:0] pdRdWord;
  logic legacyPending;
  logic [31:0] next_rdData;
  mvcr_pkg::mvcr_pd_req_s pdReq;

  logic wrCtrl;
  logic wrCmd;
  assign wrCtrl = regWrite && (regAddr == `MVCR_OFF_MSG_CTRL);
  assign wrCmd = regWrite && (regAddr == `MVCR_OFF_PD_CMD);

  ////////////////////////////////////////////////////////////////////////////
  // Message interrupt registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      msgEnable <= 1'b0; // RL1
      multiMsgEnable <= 3'h0;
      msgAddr <= 30'h00000000;
      msgUpper <= 32'h00000000;
      msgPayload <= 16'h0000;
    end else if (regWrite) begin
      if (wrCtrl) begin
        msgEnable <= regWrData[`MVCR_BIT_MSI_EN]; // RL1
        multiMsgEnable <= regWrData[`MVCR_MME_HI:`MVCR_MME_LO];
      end
      if (regAddr == `MVCR_OFF_MSG_ADDR) begin
        msgAddr <= regWrData[31:2]; // RL3
      end
      if (regAddr == `MVCR_OFF_MSG_UPPER) begin
        msgUpper <= regWrData;
      end
      if (regAddr == `MVCR_OFF_MSG_DATA) begin
        msgPayload <= regWrData[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Message write and legacy pin
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      msgWriteValid <= 1'b0;
      msgWrite <= '0;
    end else begin
      msgWriteValid <= serviceEvent && msgEnable; // RL16
      if (serviceEvent && msgEnable) begin
        msgWrite.addrLow <= {msgAddr, 2'b00}; // RL3
        msgWrite.wide <= 1'b1; // RL4
        msgWrite.addrHigh <= msgUpper; // RL4
        msgWrite.payload <= msgPayload; // RL16
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      legacyPending <= 1'b0;
      legacyIntActive <= 1'b0;
    end else begin
      if (msgEnable) begin
        legacyPending <= 1'b0; // RL1
      end else if (serviceEvent) begin
        legacyPending <= 1'b1;
      end else if (wrCtrl) begin
        legacyPending <= 1'b0;
      end
      legacyIntActive <= legacyPending && !msgEnable; // RL1
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Product data command and data
  assign pdStart = wrCmd && !pdBusy;
  assign pdReq.write = regWrData[`MVCR_BIT_PD_FLAG];
  assign pdReq.addr = regWrData[`MVCR_PD_ADDR_HI:`MVCR_PD_ADDR_LO];
  assign pdReq.data = pdWrWord; // RL11

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pdAddr <= 6'h00; // RL7
      pdFlag <= 1'b0;
    end else if (pdStart) begin
      pdAddr <= regWrData[`MVCR_PD_ADDR_HI:`MVCR_PD_ADDR_LO]; // RL7
      pdFlag <= regWrData[`MVCR_BIT_PD_FLAG]; // RL8
    end else if (pdFinish) begin
      pdFlag <= !pdFlag; // RL9
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pdWrWord <= 32'h00000000;
    end else if (regWrite && (regAddr == `MVCR_OFF_PD_WORD) && !pdBusy) begin
      pdWrWord <= regWrData; // RL11 RL17
    end else if (pdFinish && !pdFlag) begin
      pdWrWord <= pdRdWord; // RL10
    end
  end

  mvcr_eeprom_seq u_seq (
    .mclk(mclk),
    .reset_n(reset_n),
    .start(pdStart),
    .req(pdReq),
    .busy(pdBusy),
    .finish(pdFinish),
    .readWord(pdRdWord),
    .eeReq(eeReq),
    .eeCmd(eeCmd),
    .eeDone(eeDone),
    .eeReadData(eeReadData)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Test word
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      testWord0 <= `MVCR_TEST0_RESET;
    end else if (regWrite && (regAddr == `MVCR_OFF_TEST0)) begin
      testWord0 <= regWrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask
  assign irqEvent[`MVCR_IRQ_PD_DONE] = pdFinish;
  assign irqEvent[`MVCR_IRQ_MSG_SENT] = serviceEvent && msgEnable;

  genvar gi;
  generate
    for (gi = 0; gi < `MVCR_IRQ_BITS; gi = gi + 1) begin : g_irq
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          irqStatus[gi] <= 1'b0;
        end else if (irqEvent[gi]) begin
          irqStatus[gi] <= 1'b1;
        end else if (regWrite && (regAddr == `MVCR_OFF_IRQ_STATUS) && regWrData[gi]) begin
          irqStatus[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irqMask <= '0;
    end else if (regWrite && (regAddr == `MVCR_OFF_IRQ_MASK)) begin
      irqMask <= regWrData[`MVCR_IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irqStatus | irqEvent) & irqMask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer
  always_comb begin
    next_rdData = 32'h00000000;
    case (regAddr)
      `MVCR_OFF_MSG_CTRL: begin
        next_rdData[7:0] = `MVCR_MSI_CAP_ID; // RL15
        next_rdData[15:8] = `MVCR_MSI_NEXT_PTR;
        next_rdData[`MVCR_BIT_MSI_EN] = msgEnable;
        next_rdData[`MVCR_MME_HI:`MVCR_MME_LO] = multiMsgEnable;
        next_rdData[`MVCR_BIT_ADDR64] = 1'b1; // RL2
      end
      `MVCR_OFF_MSG_ADDR: next_rdData = {msgAddr, 2'b00}; // RL3
      `MVCR_OFF_MSG_UPPER: next_rdData = msgUpper;
      `MVCR_OFF_MSG_DATA: next_rdData[15:0] = msgPayload;
      `MVCR_OFF_PD_CMD: begin
        next_rdData[7:0] = `MVCR_PD_CAP_ID; // RL5
        next_rdData[15:8] = `MVCR_PD_NEXT_PTR; // RL6
        next_rdData[`MVCR_PD_ADDR_HI:`MVCR_PD_ADDR_LO] = pdAddr; // RL7
        next_rdData[`MVCR_BIT_PD_FLAG] = pdFlag; // RL8 RL9
      end
      `MVCR_OFF_PD_WORD: next_rdData = pdWrWord; // RL10
      `MVCR_OFF_VEND_HDR: begin
        next_rdData[7:0] = `MVCR_VEND_CAP_ID; // RL12
        next_rdData[15:8] = `MVCR_VEND_NEXT_PTR; // RL13
        next_rdData[31:16] = `MVCR_VEND_LENGTH; // RL14
      end
      `MVCR_OFF_TEST0: next_rdData = testWord0;
      `MVCR_OFF_IRQ_STATUS: next_rdData[`MVCR_IRQ_BITS-1:0] = irqStatus;
      `MVCR_OFF_IRQ_MASK: next_rdData[`MVCR_IRQ_BITS-1:0] = irqMask;
      default: next_rdData = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= 32'h00000000;
    end else if (regRead) begin
      regRdData <= next_rdData;
    end else begin
      regRdData <= 32'h00000000;
    end
  end

endmodule : msi_product_data_capability_header_regs
`default_nettype wire

// >>> mvcr_defines.svh
// Purpose: Offsets, fields, reset values and timing counts of the capability registers
// Assumes: 32-bit word registers at byte offsets
// Notes: Included by the package, the register bank and the EEPROM sequencer
`ifndef MVCR_DEFINES_SVH
`define MVCR_DEFINES_SVH

`define MVCR_OFF_MSG_CTRL 8'h4C
`define MVCR_OFF_MSG_ADDR 8'h50
`define MVCR_OFF_MSG_UPPER 8'h54
`define MVCR_OFF_MSG_DATA 8'h58
`define MVCR_OFF_PD_CMD 8'h5C
`define MVCR_OFF_PD_WORD 8'h60
`define MVCR_OFF_VEND_HDR 8'h64
`define MVCR_OFF_TEST0 8'h68
`define MVCR_OFF_IRQ_STATUS 8'h80
`define MVCR_OFF_IRQ_MASK 8'h84

`define MVCR_MSI_CAP_ID 8'h05
`define MVCR_MSI_NEXT_PTR 8'h64
`define MVCR_PD_CAP_ID 8'h03
`define MVCR_PD_NEXT_PTR 8'h64
`define MVCR_VEND_CAP_ID 8'h09
`define MVCR_VEND_NEXT_PTR 8'hB0
`define MVCR_VEND_LENGTH 16'h0034
`define MVCR_TEST0_RESET 32'h04001060

`define MVCR_BIT_MSI_EN 16
`define MVCR_BIT_ADDR64 23
`define MVCR_BIT_PD_FLAG 31
`define MVCR_PD_ADDR_HI 23
`define MVCR_PD_ADDR_LO 18
`define MVCR_MME_HI 22
`define MVCR_MME_LO 20

`define MVCR_IRQ_BITS 2
`define MVCR_IRQ_PD_DONE 0
`define MVCR_IRQ_MSG_SENT 1

`define MVCR_CLK_MHZ 100
`define MVCR_PD_CYCLE_NS 80
`define MVCR_PD_CYCLES ((`MVCR_PD_CYCLE_NS * `MVCR_CLK_MHZ + 999) / 1000)

`endif

// >>> mvcr_pkg.sv
// Purpose: Types shared by the capability register bank
// Assumes: Constants come from mvcr_defines.svh
// Notes: None
`include "mvcr_defines.svh"
package mvcr_pkg;

  typedef enum logic [1:0] {
    MVCR_IDLE = 2'b00,
    MVCR_BUSY = 2'b01,
    MVCR_DONE = 2'b10
  } mvcr_state_e;

  typedef struct packed {
    logic [31:0] addrLow;
    logic [31:0] addrHigh;
    logic wide;
    logic [15:0] payload;
  } mvcr_msg_s;

  typedef struct packed {
    logic write;
    logic [5:0] addr;
    logic [31:0] data;
  } mvcr_pd_req_s;

endpackage : mvcr_pkg

// >>> mvcr_eeprom_seq.sv
// Purpose: Sequences one product data table access toward the EEPROM
// Assumes: EEPROM answers with done and read data on the same clock
// Notes: Busy from start until the cycle after done is seen
`timescale 1ns/1ps
`default_nettype none
`include "mvcr_defines.svh"
module mvcr_eeprom_seq (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic start,
  input wire mvcr_pkg::mvcr_pd_req_s req,
  output logic busy,
  output logic finish,
  output logic [31:0] readWord,
  output logic eeReq,
  output mvcr_pkg::mvcr_pd_req_s eeCmd,
  input wire logic eeDone,
  input wire logic [31:0] eeReadData
);

  mvcr_pkg::mvcr_state_e state;

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencing
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= mvcr_pkg::MVCR_IDLE;
      eeReq <= 1'b0;
      eeCmd <= '0;
      finish <= 1'b0;
      readWord <= 32'h00000000;
    end else begin
      finish <= 1'b0;
      case (state)
        mvcr_pkg::MVCR_IDLE: begin
          if (start) begin
            eeCmd <= req;
            eeReq <= 1'b1;
            state <= mvcr_pkg::MVCR_BUSY;
          end
        end
        mvcr_pkg::MVCR_BUSY: begin
          if (eeDone) begin
            eeReq <= 1'b0;
            if (!eeCmd.write) begin
              readWord <= eeReadData;
            end
            state <= mvcr_pkg::MVCR_DONE;
          end
        end
        mvcr_pkg::MVCR_DONE: begin
          finish <= 1'b1;
          state <= mvcr_pkg::MVCR_IDLE;
        end
        default: begin
          state <= mvcr_pkg::MVCR_IDLE;
        end
      endcase
    end
  end

  assign busy = (state != mvcr_pkg::MVCR_IDLE);

endmodule : mvcr_eeprom_seq
`default_nettype wire

// >>> mvcr_chk_sva.sv
// Purpose: Port assertions of the capability register bank
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound from tb_top
`timescale 1ns/1ps
`default_nettype none
module mvcr_chk (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdData,
  input wire logic serviceEvent,
  input wire logic msgWriteValid,
  input wire mvcr_pkg::mvcr_msg_s msgWrite,
  input wire logic legacyIntActive,
  input wire logic irq,
  input wire logic eeReq,
  input wire mvcr_pkg::mvcr_pd_req_s eeCmd,
  input wire logic eeDone,
  input wire logic [31:0] eeReadData
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!reset_n);
  AST_MSG_CAUSE: assert property (msgWriteValid |-> $past(serviceEvent))
    else $error("message write without event");
  AST_MSG_ONE: assert property (msgWriteValid |=> !msgWriteValid)
    else $error("message write longer than one cycle");
  AST_MSG_FORM: assert property (msgWriteValid |-> msgWrite.wide && msgWrite.addrLow[1:0] == 2'h0)
    else $error("message write badly formed");
  AST_NO_LEGACY: assert property (msgWriteValid |-> !legacyIntActive)
    else $error("legacy pin active beside message");
  AST_EE_START: assert property ($rose(eeReq) |-> $past(regWrite) &&
    eeCmd.addr == $past(regWrData[23:18]) && eeCmd.write == $past(regWrData[31]))
    else $error("table access started wrongly");
  AST_EE_HOLD: assert property (eeReq && !eeDone |=> eeReq && $stable(eeCmd))
    else $error("table request dropped or changed");
  AST_EE_END: assert property (eeReq && eeDone |=> !eeReq)
    else $error("table request held after done");
  AST_VEND_HDR: assert property ($past(regRead) && $past(regAddr) == 8'h64 |->
    regRdData == 32'h0034B009) else $error("vendor header wrong");
  AST_PD_HDR: assert property ($past(regRead) && $past(regAddr) == 8'h5C |->
    regRdData[15:0] == 16'h6403) else $error("product data header wrong");
endmodule : mvcr_chk
`default_nettype wire

// >>> mvcr_ee_model.sv
// Purpose: EEPROM holding the product data table
// Assumes: Answers lat+1 cycles after the request with a one-cycle done
// Notes: Read data toggles while not answering
`timescale 1ns/1ps
`default_nettype none
module mvcr_ee_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [3:0] lat,
  input wire logic eeReq,
  input wire mvcr_pkg::mvcr_pd_req_s eeCmd,
  output logic eeDone,
  output logic [31:0] eeReadData
);
  logic [31:0] mem [0:63];
  logic [3:0] cnt;
  logic held;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 4'h0;
      held <= 1'b0;
      eeDone <= 1'b0;
      eeReadData <= 32'h0;
    end else begin
      eeDone <= 1'b0;
      eeReadData <= ~eeReadData;
      if (eeReq && !held) begin
        cnt <= cnt + 4'h1;
        if (cnt == lat) begin
          eeDone <= 1'b1;
          held <= 1'b1;
          cnt <= 4'h0;
          if (eeCmd.write) mem[eeCmd.addr] <= eeCmd.data;
          else eeReadData <= mem[eeCmd.addr];
        end
      end else if (!eeReq) held <= 1'b0;
    end
  end
endmodule : mvcr_ee_model
`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench of the capability register bank
// Assumes: EEPROM model on the table side
// Notes: Seeded shift register gives data
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk, reset_n, regWrite, regRead, serviceEvent, msgWriteValid;
  logic legacyIntActive, irq, eeReq, eeDone;
  logic [7:0] regAddr;
  logic [31:0] regWrData, regRdData, eeReadData, rdv, a, b, c, d;
  logic [3:0] lat;
  mvcr_pkg::mvcr_msg_s msgWrite;
  mvcr_pkg::mvcr_pd_req_s eeCmd;
  int n_fail, comparisons;
  logic [7:0] rA [0:10] = '{8'h4C, 8'h50, 8'h54, 8'h58, 8'h5C, 8'h60, 8'h64, 8'h68,
    8'h70, 8'h80, 8'h84};
  logic [31:0] rV [0:10] = '{32'h00806405, 32'h0, 32'h0, 32'h0, 32'h00006403, 32'h0,
    32'h0034B009, 32'h04001060, 32'h0, 32'h0, 32'h0};
  msi_product_data_capability_header_regs msi_product_data_capability_header_regs_i (.mclk(mclk), .reset_n(reset_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .serviceEvent(serviceEvent), .msgWriteValid(msgWriteValid),
    .msgWrite(msgWrite), .legacyIntActive(legacyIntActive), .irq(irq), .eeReq(eeReq),
    .eeCmd(eeCmd), .eeDone(eeDone), .eeReadData(eeReadData));
  mvcr_ee_model mvcr_ee_model_i (.mclk(mclk), .reset_n(reset_n), .lat(lat), .eeReq(eeReq),
    .eeCmd(eeCmd), .eeDone(eeDone), .eeReadData(eeReadData));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr <= ad;
    regWrData <= wd;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= ad;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 rdv = regRdData;
  endtask : rd
  task automatic ev();
    @(posedge mclk);
    serviceEvent <= 1'b1;
    @(posedge mclk);
    serviceEvent <= 1'b0;
    #1;
  endtask : ev
  task automatic poll(input logic want);
    for (int i = 0; i < 100; i++) begin
      rd(8'h5C);
      if (rdv[31] === want) return;
    end
    n_fail++;
    stop_test();
  endtask : poll
  initial begin
    reset_n = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    serviceEvent = 1'b0;
    regAddr = 8'h0;
    regWrData = 32'h0;
    lat = 4'h0;
    a = lfsr(32'h16329);
    b = lfsr(a);
    c = lfsr(b);
    d = lfsr(c);
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      rd(rA[i]);
      chk(rdv, rV[i]);
    end
    ev();
    chk(msgWriteValid, 1'b0);
    @(posedge mclk);
    #1 chk(legacyIntActive, 1'b1);
    wr(8'h50, a);
    wr(8'h54, b);
    wr(8'h58, c);
    wr(8'h4C, 32'hFFFFFFFF);
    rd(8'h50);
    chk(rdv, a & 32'hFFFFFFFC);
    rd(8'h54);
    chk(rdv, b);
    rd(8'h4C);
    chk(rdv, 32'h00F16405);
    chk(legacyIntActive, 1'b0);
    ev();
    chk(msgWriteValid, 1'b1);
    chk(msgWrite.addrLow, a & 32'hFFFFFFFC);
    chk(msgWrite.addrHigh, b);
    chk(msgWrite.wide, 1'b1);
    chk(msgWrite.payload, c[15:0]);
    rd(8'h80);
    chk(rdv, 32'h2);
    chk(irq, 1'b0);
    wr(8'h84, 32'h1);
    wr(8'h60, d);
    wr(8'h5C, 32'h80FC0000);
    poll(1'b0);
    chk(mvcr_ee_model_i.mem[63], d);
    chk(irq, 1'b1);
    rd(8'h5C);
    chk(rdv, 32'h00FC6403);
    wr(8'h60, ~d);
    lat <= 4'h7;
    wr(8'h5C, 32'h00FC0000);
    poll(1'b1);
    rd(8'h60);
    chk(rdv, d);
    wr(8'h80, 32'h3);
    @(posedge mclk);
    #1 chk(irq, 1'b0);
    stop_test();
  end
endmodule : tb_top
bind msi_product_data_capability_header_regs mvcr_chk mvcr_chk_i (.mclk(mclk), .reset_n(reset_n),
  .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .serviceEvent(serviceEvent), .msgWriteValid(msgWriteValid),
  .msgWrite(msgWrite), .legacyIntActive(legacyIntActive), .irq(irq), .eeReq(eeReq),
  .eeCmd(eeCmd), .eeDone(eeDone), .eeReadData(eeReadData));
`default_nettype wire
